// file: rrero_defs.svh
// Register map, reset values and timing figures of the rise offset block
`ifndef RRERO_DEFS_SVH
`define RRERO_DEFS_SVH

// Register addresses
`define RRERO_ADDR_RISE_OFS  8'h4d
`define RRERO_ADDR_CTRL      8'h60
`define RRERO_ADDR_PER_LO    8'h61
`define RRERO_ADDR_PER_HI    8'h62
`define RRERO_ADDR_STATUS    8'h63

// Reset values
`define RRERO_RST_RISE_OFS   8'h00
`define RRERO_RST_CTRL       1'b0
`define RRERO_RST_PERIOD     16'd1000
`define RRERO_RST_RDATA      8'h00
`define RRERO_UNMAPPED_READ  8'h00

// Field positions
`define RRERO_CTRL_EN_BIT    0
`define RRERO_STAT_OUT_BIT   0
`define RRERO_STAT_FINE_BIT  1
`define RRERO_STAT_STATE_LO  2
`define RRERO_STAT_STATE_HI  3
`define RRERO_OFS_SIGN_BIT   7

// Timing figures
`define RRERO_STEP_NS        5
`define RRERO_CLK_NS         10
`define RRERO_CODE_SPAN      256
`define RRERO_MIN_PERIOD     2

`endif

// file: rrero_pkg.sv
// Types shared by the rise offset block
`default_nettype none

package rrero_pkg;

    // Register access strobes and data
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } rrero_bus_t;

    // Drive to the gate driver pin
    typedef struct packed {
        logic level;
        logic fine;
    } rrero_pin_t;

    // Phase of the fourth output within a switching cycle
    typedef enum logic [1:0] {
        RRERO_IDLE,
        RRERO_WAIT,
        RRERO_HIGH
    } rrero_state_t;

endpackage

`default_nettype wire

// file: rrero_cycle_timer.sv
// Switching cycle counter for the rise offset block
`timescale 1ns/1ns
`default_nettype none
`include "rrero_defs.svh"

module rrero_cycle_timer #(
    parameter int PW = 16
) (
    // Clock and reset
    input  wire logic          mclk,
    input  wire logic          nrst,
    // Control
    input  wire logic          enable,
    input  wire logic [PW-1:0] period,
    // Cycle position
    output logic      [PW-1:0] count,
    output logic      [PW-1:0] period_now,
    output logic               last
);

    wire logic [PW-1:0] period_safe;

    if (PW < 2 || PW > 24) begin : g_bad_width
        $error("rrero_cycle_timer: PW out of range");
    end

    // Periods below the minimum are raised to it
    assign period_safe = (period < PW'(`RRERO_MIN_PERIOD)) ?
                         PW'(`RRERO_MIN_PERIOD) : period;
    assign last        = enable && (count == period_now - PW'(1));

    always_ff @(posedge mclk) begin
        if (!nrst || !enable) begin
            count      <= '0;
            period_now <= PW'(`RRERO_RST_PERIOD);
        end else if (last) begin
            count      <= '0;
            period_now <= period_safe;
        end else begin
            count      <= count + PW'(1);
        end
    end

endmodule
`default_nettype wire

// file: rrero_core.sv
// Rising edge placement of the fourth PWM output in resonant mode
//
// Local design decision: strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "rrero_defs.svh"

// Behaviour
// - 8-bit field sets fourth output rise position
// - One code step moves edge 5 ns
// - Codes 0x00-0x7F trail midpoint by code*5ns
// - Codes 0x80-0xFF lead by (256-code)*5ns
module rrero_core #(
    parameter int PW = 16
) (
    // Clock and reset
    input  wire logic                mclk,
    input  wire logic                nrst,
    // Register port
    input  wire rrero_pkg::rrero_bus_t bus,
    output logic               [7:0] rdata,
    // Gate driver pin
    output rrero_pkg::rrero_pin_t    fourth_pwm_output,
    // Cycle marker
    output logic                     cycle_last
);
    import rrero_pkg::*;

    localparam int SPC = `RRERO_CLK_NS / `RRERO_STEP_NS;
    localparam int ST  = PW + 2;

    if (SPC != 2 || (`RRERO_CLK_NS % `RRERO_STEP_NS) != 0) begin : g_bad_step
        $error("rrero_core: clock must be two offset steps");
    end
    if (PW < 8 || PW > 16) begin : g_bad_width
        $error("rrero_core: PW must be 8 to 16");
    end

    // Edge time in offset steps, measured from the cycle start
    function automatic logic signed [ST:0] rrero_place(
        input logic [ST-1:0] mid,
        input logic [7:0]    code
    );
        logic signed [ST:0] ofs;
        ofs = $signed({{(ST-7){code[`RRERO_OFS_SIGN_BIT]}}, code});
        rrero_place = $signed({1'b0, mid}) + ofs;
    endfunction

    // Registers
    logic         [7:0] rise_offset_four;
    logic               mode_en;
    logic      [PW-1:0] period;
    logic         [7:0] lat_code;
    rrero_state_t       state;

    // Timer view
    logic      [PW-1:0] count;
    logic      [PW-1:0] period_now;
    logic               last;

    // Decode
    wire logic          hit_ofs;
    wire logic          hit_ctrl;
    wire logic          hit_plo;
    wire logic          hit_phi;
    wire logic          hit_stat;
    wire logic    [7:0] rd_mux;
    wire logic    [7:0] stat_word;

    // Edge arithmetic
    wire logic   [ST-1:0] mid_steps;
    wire logic   [ST-1:0] lim_steps;
    wire logic signed [ST:0] edge_raw;
    wire logic   [ST-1:0] edge_steps;
    wire logic   [ST-2:0] edge_clk;
    wire logic            edge_fine;
    wire logic            past_edge;
    rrero_state_t         next_state;

    rrero_cycle_timer #(
        .PW         (PW)
    ) u_timer (
        .mclk       (mclk),
        .nrst       (nrst),
        .enable     (mode_en),
        .period     (period),
        .count      (count),
        .period_now (period_now),
        .last       (last)
    );

    assign cycle_last = last;

    // Address decoding
    assign hit_ofs  = (bus.addr == `RRERO_ADDR_RISE_OFS);
    assign hit_ctrl = (bus.addr == `RRERO_ADDR_CTRL);
    assign hit_plo  = (bus.addr == `RRERO_ADDR_PER_LO);
    assign hit_phi  = (bus.addr == `RRERO_ADDR_PER_HI);
    assign hit_stat = (bus.addr == `RRERO_ADDR_STATUS);

    assign stat_word = {4'h0, state,
                        fourth_pwm_output.fine,
                        fourth_pwm_output.level};

    assign rd_mux =
        hit_ofs  ? rise_offset_four :
        hit_ctrl ? {7'h00, mode_en} :
        hit_plo  ? 8'(period) :
        hit_phi  ? 8'(period >> 8) :
        hit_stat ? stat_word :
        `RRERO_UNMAPPED_READ;

    // Register writes
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rise_offset_four <= `RRERO_RST_RISE_OFS;
            mode_en          <= `RRERO_RST_CTRL;
            period           <= PW'(`RRERO_RST_PERIOD);
        end else if (bus.wr) begin
            if (hit_ofs) begin
                rise_offset_four <= bus.wdata;
            end else if (hit_ctrl) begin
                mode_en <= bus.wdata[`RRERO_CTRL_EN_BIT];
            end else if (hit_plo) begin
                period <= PW'({8'(period >> 8), bus.wdata});
            end else if (hit_phi) begin
                period <= PW'({bus.wdata, period[7:0]});
            end
        end
    end

    // Read data one cycle after the strobe, held otherwise at zero
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rdata <= `RRERO_RST_RDATA;
        end else if (bus.rd) begin
            rdata <= rd_mux;
        end else begin
            rdata <= `RRERO_RST_RDATA;
        end
    end

    // Offset taken at each cycle boundary so one cycle sees one code
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            lat_code <= `RRERO_RST_RISE_OFS;
        end else if (last || !mode_en) begin
            lat_code <= rise_offset_four;
        end
    end

    // Midpoint in steps: half of the current period
    assign mid_steps = ST'((ST'(period_now) * ST'(SPC)) >> 1);
    assign lim_steps = ST'(ST'(period_now) * ST'(SPC)) - ST'(1);

    // Signed code: low half trails, high half leads the midpoint
    assign edge_raw  = rrero_place(mid_steps, lat_code);

    // Edge kept inside the current cycle
    assign edge_steps = (edge_raw < 0) ? '0 :
                        (edge_raw > $signed({1'b0, lim_steps})) ?
                        lim_steps : ST'(edge_raw);

    // Whole clocks and the remaining 5 ns step
    assign edge_clk  = edge_steps[ST-1:1];
    assign edge_fine = edge_steps[0];
    assign past_edge = ({2'b00, count} >= {1'b0, edge_clk});

    always_comb begin
        next_state = state;
        case (state)
            RRERO_IDLE: begin
                if (mode_en) begin
                    next_state = RRERO_WAIT;
                end
            end
            RRERO_WAIT: begin
                if (!mode_en) begin
                    next_state = RRERO_IDLE;
                end else if (past_edge && !last) begin
                    next_state = RRERO_HIGH;
                end
            end
            RRERO_HIGH: begin
                if (!mode_en) begin
                    next_state = RRERO_IDLE;
                end else if (last) begin
                    next_state = RRERO_WAIT;
                end
            end
            default: begin
                next_state = RRERO_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state <= RRERO_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Pin drive, fine flag marks the extra half-clock delay
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            fourth_pwm_output <= '0;
        end else begin
            fourth_pwm_output.level <= (next_state == RRERO_HIGH);
            fourth_pwm_output.fine  <= mode_en && edge_fine;
        end
    end

    // Checks
    property p_code_latch;
        @(posedge mclk) disable iff (!nrst)
        (mode_en && last) |=> (lat_code == $past(rise_offset_four));
    endproperty
    a_code_latch: assert property (p_code_latch)
        else $error("offset code not taken at cycle boundary");

    property p_step;
        @(posedge mclk) disable iff (!nrst)
        (mode_en && !(edge_raw < 0) &&
         !(edge_raw > $signed({1'b0, lim_steps})))
        |=> (fourth_pwm_output.fine ==
             ($past(period_now[0]) ^ $past(lat_code[0])));
    endproperty
    a_step: assert property (p_step)
        else $error("edge split into clocks and steps is wrong");

    property p_trail;
        @(posedge mclk) disable iff (!nrst)
        (mode_en && !lat_code[`RRERO_OFS_SIGN_BIT] &&
         (mid_steps + ST'(lat_code) <= lim_steps))
        |-> (edge_steps == mid_steps + ST'(lat_code));
    endproperty
    a_trail: assert property (p_trail)
        else $error("trailing edge not at midpoint plus code");

    property p_lead;
        @(posedge mclk) disable iff (!nrst)
        (mode_en && lat_code[`RRERO_OFS_SIGN_BIT] &&
         (mid_steps >= ST'(`RRERO_CODE_SPAN) - ST'(lat_code)))
        |-> (edge_steps ==
             mid_steps - (ST'(`RRERO_CODE_SPAN) - ST'(lat_code)));
    endproperty
    a_lead: assert property (p_lead)
        else $error("leading edge not at midpoint minus span");

    property p_mid;
        @(posedge mclk) disable iff (!nrst)
        mode_en |-> (ST'(mid_steps * ST'(2)) ==
                     ST'(ST'(period_now) * ST'(SPC)));
    endproperty
    a_mid: assert property (p_mid)
        else $error("midpoint is not half the period");

    property p_rise;
        @(posedge mclk) disable iff (!nrst)
        (state == RRERO_WAIT && mode_en && !last &&
         count == PW'(edge_clk))
        |=> fourth_pwm_output.level ##1 (fourth_pwm_output.level || 
            $past(last) || !$past(mode_en));
    endproperty
    a_rise: assert property (p_rise)
        else $error("rise not produced at edge clock");

    property p_low_before;
        @(posedge mclk) disable iff (!nrst)
        (mode_en && $rose(mode_en)) |=> !fourth_pwm_output.level [*2];
    endproperty
    a_low_before: assert property (p_low_before)
        else $error("output high too early after enable");

    property p_cycle_end;
        @(posedge mclk) disable iff (!nrst)
        (mode_en && last && rise_offset_four == 8'h00)
        |=> !fourth_pwm_output.level [*2];
    endproperty
    a_cycle_end: assert property (p_cycle_end)
        else $error("output not low at cycle start");

    property p_off;
        @(posedge mclk) disable iff (!nrst)
        !mode_en |=> (fourth_pwm_output == '0);
    endproperty
    a_off: assert property (p_off)
        else $error("output not low while mode is off");

    property p_period;
        @(posedge mclk) disable iff (!nrst)
        (mode_en && last && period >= PW'(`RRERO_MIN_PERIOD))
        |=> (period_now == $past(period));
    endproperty
    a_period: assert property (p_period)
        else $error("period not taken at cycle boundary");

    c_trail: cover property (@(posedge mclk) disable iff (!nrst)
        mode_en && !lat_code[`RRERO_OFS_SIGN_BIT] &&
        $rose(fourth_pwm_output.level));
    c_lead: cover property (@(posedge mclk) disable iff (!nrst)
        mode_en && lat_code[`RRERO_OFS_SIGN_BIT] &&
        $rose(fourth_pwm_output.level));
    c_fine: cover property (@(posedge mclk) disable iff (!nrst)
        fourth_pwm_output.fine && fourth_pwm_output.level);
    c_clamp: cover property (@(posedge mclk) disable iff (!nrst)
        mode_en && edge_raw < 0);

endmodule
`default_nettype wire

// file: rrero_gate_model.sv
// Gate driver model that times the rising edge of the fourth output
`timescale 1ns/1ns
`default_nettype none

module rrero_gate_model (
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  nrst,
    // Drive from the block
    input  wire rrero_pkg::rrero_pin_t pin,
    input  wire logic                  cycle_last,
    // Last edge seen, in 5 ns units from cycle start
    output logic                [15:0] rise_pos
);
    import rrero_pkg::*;

    logic [15:0] clk_cnt;
    logic        level_q;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            clk_cnt  <= 16'h0000;
            level_q  <= 1'b0;
            rise_pos <= 16'hffff;
        end else begin
            clk_cnt <= cycle_last ? 16'h0000 : clk_cnt + 16'h0001;
            level_q <= pin.level;
            // Level lags its edge clock by one; fine adds half a clock
            if (pin.level && !level_q) begin
                rise_pos <= {clk_cnt[14:0] - 15'h0001, pin.fine};
            end
        end
    end
endmodule

`default_nettype wire

// file: resonant_rise_edge_offset_tb.sv
// Self-checking testbench of the rise offset block
`timescale 1ns/1ns
`default_nettype none
`include "rrero_defs.svh"

module resonant_rise_edge_offset_tb;
    import rrero_pkg::*;

    logic        mclk;
    logic        nrst;
    rrero_bus_t  bus;
    logic [7:0]  rdata;
    rrero_pin_t  pin;
    logic        cycle_last;
    logic [15:0] rise_pos;
    logic [15:0] period;
    logic [15:0] n;
    int          mismatches;
    int          check_count;

    rrero_core DUT (
        .mclk              (mclk),
        .nrst              (nrst),
        .bus               (bus),
        .rdata             (rdata),
        .fourth_pwm_output (pin),
        .cycle_last        (cycle_last)
    );

    rrero_gate_model model (
        .mclk       (mclk),
        .nrst       (nrst),
        .pin        (pin),
        .cycle_last (cycle_last),
        .rise_pos   (rise_pos)
    );

    always #5 mclk = ~mclk;

    task automatic conclude();
        if (mismatches == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus.rd <= 1'b0;
        @(negedge mclk);
        chk({8'h00, rdata}, {8'h00, exp});
        @(negedge mclk);
        chk({8'h00, rdata}, 16'h0000);
    endtask

    // Counts clocks up to and including the next cycle end
    task automatic wait_last(output logic [15:0] cnt);
        @(negedge mclk);
        for (cnt = 16'h0001; cycle_last !== 1'b1; cnt++) begin
            if (cnt == 16'h0800) begin
                mismatches++;
                conclude();
            end
            @(negedge mclk);
        end
    endtask

    // New code takes hold at the next boundary; measure the second cycle after it
    task automatic rise(input logic [7:0] code);
        wr_reg(`RRERO_ADDR_RISE_OFS, code);
        repeat (3) wait_last(n);
        chk(rise_pos, period + {{8{code[7]}}, code});
    endtask

    initial begin
        mclk = 1'b0;
        nrst = 1'b0;
        bus = '0;
        mismatches = 0;
        check_count = 0;
        period = 16'h00c8;
        repeat (6) @(posedge mclk);
        nrst <= 1'b1;
        rd_chk(`RRERO_ADDR_RISE_OFS, `RRERO_RST_RISE_OFS);
        rd_chk(8'h10, `RRERO_UNMAPPED_READ);
        wr_reg(`RRERO_ADDR_RISE_OFS, 8'ha5);
        rd_chk(`RRERO_ADDR_RISE_OFS, 8'ha5);
        wr_reg(`RRERO_ADDR_PER_LO, period[7:0]);
        wr_reg(`RRERO_ADDR_PER_HI, period[15:8]);
        rd_chk(`RRERO_ADDR_STATUS, 8'h00);
        wr_reg(`RRERO_ADDR_CTRL, 8'h01);
        rd_chk(`RRERO_ADDR_CTRL, 8'h01);
        rd_chk(`RRERO_ADDR_PER_LO, period[7:0]);
        rd_chk(`RRERO_ADDR_PER_HI, period[15:8]);
        rise(8'h00);
        rise(8'h01);
        rise(8'h02);
        rise(8'h7f);
        rise(8'h80);
        rise(8'hff);
        rise(8'hfe);
        period = 16'h0096;
        wr_reg(`RRERO_ADDR_PER_LO, period[7:0]);
        rise(8'h05);
        wait_last(n);
        chk(n, period);
        rise(8'h81);
        wr_reg(`RRERO_ADDR_CTRL, 8'h00);
        repeat (2) @(negedge mclk);
        chk({13'h0000, cycle_last, pin}, 16'h0000);
        @(posedge mclk);
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        rd_chk(`RRERO_ADDR_RISE_OFS, `RRERO_RST_RISE_OFS);
        rd_chk(`RRERO_ADDR_CTRL, 8'h00);
        conclude();
    end
endmodule

`default_nettype wire
